// ==== rtl/ita_consts.vh ====
`ifndef ITA_CONSTS_VH
`define ITA_CONSTS_VH
// Fixed upper address bits
`define ITA_ADDR_B7 1'b0
`define ITA_ADDR_B6 1'b1
// Resistor strap levels (decoded level index)
`define ITA_LVL_GND 3'h0
`define ITA_LVL_OPEN 3'h7
// Address field codes
`define ITA_CODE_GND 4'h0
`define ITA_CODE_OPEN 4'hf
// Stretch release bound
`define ITA_REL_NS 100
`define ITA_CLK_NS 10
`define ITA_REL_CYC (`ITA_REL_NS / `ITA_CLK_NS)
`endif

// ==== rtl/ita_strap_latch.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ita_consts.vh"
module ita_strap_latch (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Sample strobe and straps
   input wire sample,
   input wire addr_strap_low_bit,
   input wire addr_strap_high_bit,
   input wire [2:0] strap_level,
   // Port masks and overrides
   input wire [6:0] mask_a,
   input wire [6:0] ovr_a,
   input wire [6:0] mask_b,
   input wire [6:0] ovr_b,
   // Result
   output reg [6:0] addr_a,
   output reg [6:0] addr_b,
   output reg addr_valid
);
   reg [6:0] raw_r;
   reg [3:0] code;

   // level to field code; open maps to 0x0f
   always @* begin
      if (strap_level == `ITA_LVL_OPEN)
         code = `ITA_CODE_OPEN;
      else
         code = {1'b0, strap_level};
   end

   always @(posedge clk) begin
      if (!nrst) begin
         raw_r <= 7'h00;
         addr_valid <= 1'b0;
      end else if (sample) begin
         // assemble address; open code keeps only its low three bits
         raw_r <= {`ITA_ADDR_B7, `ITA_ADDR_B6, addr_strap_high_bit,
                   addr_strap_low_bit, code[2:0]};
         addr_valid <= 1'b1;
      end
   end

   always @* begin
      addr_a = (raw_r & ~mask_a) | (ovr_a & mask_a);
      addr_b = (raw_r & ~mask_b) | (ovr_b & mask_b);
   end
endmodule
`default_nettype wire

// ==== rtl/ita_target.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ita_consts.vh"
// Behaviour
// - After a byte other than a write address, hold SCL low until the core is ready or REL_CYC cycles pass.
// - Stretch starts only at the eighth-bit SCL fall, just before the acknowledge.
// - No address acknowledged until boot has fixed the address.
// - Address is 0,1,strap high,strap low,three code bits.
// - Each port masks any address bit independently.
// - Ground gives 0, levels 1 to 6, open gives 0x0f.
// - Digital straps sampled with the resistor decode.
// - Address assembled by core logic from sampled straps.
// - Byte after a write address is the sub-address.
// - Matching address acknowledged by pulling SDA low.
module ita_target #(
   parameter REL_CYC = `ITA_REL_CYC
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Boot strap capture
   input wire boot_sample,
   input wire addr_strap_low_bit,
   input wire addr_strap_high_bit,
   input wire [2:0] strap_level,
   // Firmware address override, port selects which mask applies
   input wire port_sel,
   input wire [6:0] mask_a,
   input wire [6:0] ovr_a,
   input wire [6:0] mask_b,
   input wire [6:0] ovr_b,
   // Bus pins
   input wire scl_in,
   output wire scl_out,
   output wire scl_oe,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   // Core side
   input wire core_ready,
   input wire [7:0] tx_data,
   output reg [7:0] sub_addr,
   output reg sub_valid,
   output reg [7:0] rx_data,
   output reg rx_valid,
   output reg rd_req,
   output reg busy
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_ACK = 3'h2;
   localparam ST_SUB = 3'h3;
   localparam ST_WR = 3'h4;
   localparam ST_RD = 3'h5;
   localparam ST_RACK = 3'h6;

   wire [6:0] addr_a;
   wire [6:0] addr_b;
   wire addr_valid;
   reg scl_d_r, sda_d_r;
   reg [2:0] st_r;
   reg [2:0] nxt_st_r;
   reg [3:0] bit_r;
   reg [7:0] sh_r;
   reg drv_r, stretch_r;
   reg [7:0] rel_cnt_r;

   ita_strap_latch u_latch (
      .clk(clk),
      .nrst(nrst),
      .sample(boot_sample),
      .addr_strap_low_bit(addr_strap_low_bit),
      .addr_strap_high_bit(addr_strap_high_bit),
      .strap_level(strap_level),
      .mask_a(mask_a),
      .ovr_a(ovr_a),
      .mask_b(mask_b),
      .ovr_b(ovr_b),
      .addr_a(addr_a),
      .addr_b(addr_b),
      .addr_valid(addr_valid)
   );

   wire [6:0] own_addr = port_sel ? addr_b : addr_a;

   // a hit needs a latched address
   function match_f;
      input [7:0] byte_v;
      input [6:0] addr_v;
      input valid_v;
      begin
         match_f = valid_v && (byte_v[7:1] == addr_v);
      end
   endfunction

   wire addr_hit = match_f(sh_r, own_addr, addr_valid);
   wire scl_rise = scl_in & ~scl_d_r;
   wire scl_fall = ~scl_in & scl_d_r;
   wire start_c = scl_in & scl_d_r & sda_d_r & ~sda_in;
   wire stop_c = scl_in & scl_d_r & ~sda_d_r & sda_in;

   assign scl_out = 1'b0;
   assign scl_oe = stretch_r;
   // open-drain SDA: drive low for ack or zero data bit
   assign sda_out = 1'b0;
   assign sda_oe = drv_r;

   always @(posedge clk) begin
      if (!nrst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         st_r <= ST_IDLE;
         nxt_st_r <= ST_IDLE;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         drv_r <= 1'b0;
         stretch_r <= 1'b0;
         rel_cnt_r <= 8'h00;
         sub_addr <= 8'h00;
         sub_valid <= 1'b0;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         rd_req <= 1'b0;
         busy <= 1'b0;
      end else begin
         scl_d_r <= scl_in;
         sda_d_r <= sda_in;
         sub_valid <= 1'b0;
         rx_valid <= 1'b0;
         rd_req <= 1'b0;
         if (stretch_r) begin
            // release on ready, or after bounded count
            rel_cnt_r <= rel_cnt_r + 8'h01;
            if (core_ready || rel_cnt_r >= REL_CYC[7:0] - 8'h01) begin
               stretch_r <= 1'b0;
               rel_cnt_r <= 8'h00;
            end
         end
         if (start_c) begin
            st_r <= ST_ADDR;
            bit_r <= 4'h0;
            drv_r <= 1'b0;
            busy <= 1'b1;
         end else if (stop_c) begin
            st_r <= ST_IDLE;
            drv_r <= 1'b0;
            busy <= 1'b0;
         end else begin
            case (st_r)
               ST_IDLE: drv_r <= 1'b0;
               ST_ADDR, ST_SUB, ST_WR: begin
                  if (scl_rise) begin
                     sh_r <= {sh_r[6:0], sda_in};
                     bit_r <= bit_r + 4'h1;
                  end
                  if (scl_fall && bit_r == 4'h8) begin
                     bit_r <= 4'h0;
                     if (st_r == ST_ADDR) begin
                        // no ack before address is set
                        drv_r <= addr_hit;
                        nxt_st_r <= sh_r[0] ? ST_RD : ST_SUB;
                        st_r <= addr_hit ? ST_ACK : ST_IDLE;
                        if (addr_hit && sh_r[0]) begin
                           rd_req <= 1'b1;
                           stretch_r <= ~core_ready;
                        end
                     end else if (st_r == ST_SUB) begin
                        sub_addr <= sh_r;
                        sub_valid <= 1'b1;
                        drv_r <= 1'b1;
                        nxt_st_r <= ST_WR;
                        st_r <= ST_ACK;
                        // hold clock until core takes the byte
                        stretch_r <= ~core_ready;
                     end else begin
                        rx_data <= sh_r;
                        rx_valid <= 1'b1;
                        drv_r <= 1'b1;
                        nxt_st_r <= ST_WR;
                        st_r <= ST_ACK;
                        stretch_r <= ~core_ready;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     st_r <= nxt_st_r;
                     if (nxt_st_r == ST_RD) begin
                        sh_r <= {tx_data[6:0], 1'b0};
                        drv_r <= ~tx_data[7];
                        bit_r <= 4'h1;
                     end else begin
                        drv_r <= 1'b0;
                     end
                  end
               end
               ST_RD: begin
                  if (scl_fall) begin
                     if (bit_r == 4'h8) begin
                        drv_r <= 1'b0;
                        st_r <= ST_RACK;
                        // stretch before acknowledge; stretching at the ack rise would cut SCL high
                        stretch_r <= ~core_ready;
                     end else begin
                        drv_r <= ~sh_r[7];
                        sh_r <= {sh_r[6:0], 1'b0};
                        bit_r <= bit_r + 4'h1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     if (sda_in) begin
                        st_r <= ST_IDLE;
                     end else begin
                        nxt_st_r <= ST_RD;
                        st_r <= ST_ACK;
                        rd_req <= 1'b1;
                     end
                  end
               end
               default: st_r <= ST_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/ita_target_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module ita_target_sva #(
   parameter REL_CYC = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Observed ports
   input wire logic boot_sample,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic core_ready,
   input wire logic sub_valid,
   input wire logic rx_valid,
   input wire logic busy
);
   localparam int REL_MAX = REL_CYC + 2;
   reg booted_r;
   always @(posedge clk) begin
      if (!nrst) booted_r <= 1'b0;
      else if (boot_sample) booted_r <= 1'b1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_PINS_LOW: assert property (!scl_out && !sda_out) else $error("pin driven high");
   AST_RESET_QUIET: assert property ($rose(nrst) |-> !scl_oe && !sda_oe && !busy)
      else $error("output active after reset");
   AST_NO_ACK_UNBOOTED: assert property (!booted_r |-> !sda_oe) else $error("ack before boot");
   AST_BOUNDED_STRETCH: assert property ($rose(scl_oe) |-> ##[1:REL_MAX] !scl_oe)
      else $error("stretch too long");
   AST_READY_RELEASE: assert property (scl_oe && core_ready |-> ##[1:3] !scl_oe)
      else $error("stretch kept while ready");
   AST_STRETCH_LOW: assert property ($rose(scl_oe) |-> !scl_in && busy)
      else $error("stretch outside low phase");
   AST_SDA_STABLE: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("sda moved while scl high");
   AST_SDA_IN_FRAME: assert property (sda_oe |-> busy) else $error("sda driven idle");
   AST_SUB_PULSE: assert property (sub_valid |=> !sub_valid) else $error("sub pulse long");
   AST_RX_PULSE: assert property (rx_valid |-> busy ##1 !rx_valid)
      else $error("rx pulse bad");
   COV_STRETCH: cover property ($rose(scl_oe));
   COV_READY: cover property (scl_oe && core_ready);
   COV_ACK: cover property ($rose(sda_oe) && !scl_in);
   COV_SUB: cover property (sub_valid);
   COV_RX: cover property (rx_valid);
endmodule
bind ita_target ita_target_sva #(.REL_CYC(REL_CYC)) ita_target_sva_inst (.clk(clk), .nrst(nrst),
   .boot_sample(boot_sample), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
   .sda_out(sda_out), .sda_oe(sda_oe), .core_ready(core_ready), .sub_valid(sub_valid),
   .rx_valid(rx_valid), .busy(busy));
`default_nettype wire

// ==== test/ita_bus.sv ====
`timescale 1ns/1ps
`default_nettype none
module ita_bus (
   // Clock
   input wire logic clk,
   // Target pull-down enables
   input wire logic scl_oe,
   input wire logic sda_oe,
   // Wire levels
   output wire logic scl,
   output wire logic sda
);
   logic scl_lo = 1'b0;
   logic sda_lo = 1'b0;
   int stretches = 0;
   // Open drain with pull-ups, released lines read high
   assign scl = !(scl_lo || scl_oe);
   assign sda = !(sda_lo || sda_oe);
   task automatic hc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic bt(input logic d, output logic b);
      int w;
      sda_lo = !d;
      hc(10);
      scl_lo = 1'b0;
      w = 0;
      hc(1);
      while (!scl && w < 2000) begin
         hc(1);
         w++;
      end
      if (w > 0) stretches++;
      if (w > 0) hc(400);
      hc(20);
      b = sda;
      scl_lo = 1'b1;
      hc(20);
   endtask
   task automatic start();
      sda_lo = 1'b1;
      hc(20);
      scl_lo = 1'b1;
      hc(10);
   endtask
   task automatic stop();
      sda_lo = 1'b1;
      hc(10);
      scl_lo = 1'b0;
      hc(20);
      sda_lo = 1'b0;
      hc(20);
   endtask
   task automatic wr(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bt(v[i], b);
      bt(1'b1, b);
      ack = !b;
   endtask
   task automatic rd(output logic [7:0] v);
      logic b;
      for (int i = 7; i >= 0; i--) bt(1'b1, v[i]);
      bt(1'b1, b);
   endtask
endmodule
`default_nettype wire

// ==== test/ita_target_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ita_target_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0, boot_sample = 1'b0, s_lo = 1'b0, s_hi = 1'b0, port_sel = 1'b0;
   logic core_ready = 1'b0, ack;
   logic [1:0] rdy_mode = 2'h0;
   logic [2:0] lvl = 3'h0;
   logic [6:0] mask_a = 7'h00, ovr_a = 7'h00, mask_b = 7'h00, ovr_b = 7'h00;
   logic [7:0] tx_data = 8'h00, sub_got, rx_got, d;
   wire scl, sda, scl_oe, sda_oe, sub_valid, rx_valid, rd_req, busy;
   wire [7:0] sub_addr, rx_data;
   integer seed = 32'h6959;
   int errors = 0, cmp_count = 0, ea, m, o, rd_cnt = 0, oe_cnt = 0;
   // Timeout longer than the controller's 30 cycle low phase, so timed-out stretches are seen
   ita_target #(.REL_CYC(200)) ita_target_inst (.clk(clk), .nrst(nrst), .boot_sample(boot_sample),
      .addr_strap_low_bit(s_lo), .addr_strap_high_bit(s_hi), .strap_level(lvl),
      .port_sel(port_sel), .mask_a(mask_a), .ovr_a(ovr_a), .mask_b(mask_b), .ovr_b(ovr_b),
      .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .core_ready(core_ready), .tx_data(tx_data), .sub_addr(sub_addr), .sub_valid(sub_valid),
      .rx_data(rx_data), .rx_valid(rx_valid), .rd_req(rd_req), .busy(busy));
   ita_bus ita_bus_inst (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      if (sub_valid) sub_got <= sub_addr;
      if (rx_valid) rx_got <= rx_data;
      if (rd_req) rd_cnt <= rd_cnt + 1;
   end
   // Mode 0 never ready, 1 and 3 ready, 2 ready 20 cycles into a stretch
   always @(negedge clk) begin
      oe_cnt <= scl_oe ? oe_cnt + 1 : 0;
      core_ready <= rdy_mode[0] || (rdy_mode[1] && oe_cnt >= 20);
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      // About twice the expected run length
      repeat (60000) @(posedge clk);
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      ita_bus_inst.start();
      ita_bus_inst.wr(8'h40, ack);
      ita_bus_inst.stop();
      chk(ack, 0);
      for (int i = 0; i < 8; i++) begin
         {s_hi, s_lo, port_sel} = $random(seed);
         {mask_a, ovr_a, mask_b, ovr_b} = $random(seed);
         lvl = i;
         // fixed bits, straps, open level truncated to three bits
         ea = 32 + s_hi * 16 + s_lo * 8 + (lvl == 7 ? 15 : lvl) % 8;
         m = port_sel ? mask_b : mask_a;
         o = port_sel ? ovr_b : ovr_a;
         ea = (ea & ~m | o & m) & 127;
         boot_sample = 1'b1;
         @(negedge clk);
         boot_sample = 1'b0;
         {s_hi, s_lo, lvl, tx_data} = $random(seed);
         rdy_mode = i[1:0];
         ita_bus_inst.start();
         ita_bus_inst.wr({ea[6:1], ~ea[0], 1'b0}, ack);
         ita_bus_inst.stop();
         chk(ack, 0);
         ita_bus_inst.start();
         ita_bus_inst.wr({ea[6:0], 1'b0}, ack);
         chk(ack, 1);
         d = $random(seed);
         ita_bus_inst.wr(d, ack);
         chk(ack, 1);
         chk(sub_got, d);
         ita_bus_inst.wr(~d, ack);
         chk(ack, 1);
         chk(rx_got, ~d);
         ita_bus_inst.stop();
         ita_bus_inst.start();
         ita_bus_inst.wr({ea[6:0], 1'b1}, ack);
         chk(ack, 1);
         ita_bus_inst.rd(d);
         ita_bus_inst.stop();
         chk(d, tx_data);
      end
      chk(ita_bus_inst.stretches != 0, 1);
      chk(rd_cnt, 8);
      chk(busy, 0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
